// ---- bert_pkg.sv ----
// Shared constants, register map, field layout and types of the bit error rate tester.
package bert_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_PATTERN_SET = 8'h00;
  localparam logic [7:0] OFF_PATTERN_LENGTH = 8'h04;
  localparam logic [7:0] OFF_TAP_SELECT = 8'h08;
  localparam logic [7:0] OFF_PATTERN_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_ERROR_INSERT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RECEIVED_PATTERN = 8'h18;
  localparam logic [7:0] OFF_ERROR_COUNT = 8'h1c;
  localparam logic [7:0] OFF_BIT_COUNT = 8'h20;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned PCR_MODE_BIT = 0;
  localparam int unsigned PCR_SYNC_EN_BIT = 1;
  localparam int unsigned PCR_RESYNC_BIT = 2;
  localparam int unsigned PCR_INT_EN_BIT = 3;
  localparam int unsigned PCR_LC_BIT = 4;
  localparam int unsigned PCR_TL_BIT = 7;
  localparam int unsigned EIR_RATE_LSB = 0;
  localparam int unsigned EIR_RATE_W = 3;
  localparam int unsigned EIR_SINGLE_BIT = 3;
  localparam int unsigned ST_SYNC_BIT = 0;
  localparam int unsigned ST_ALL_ZERO_BIT = 1;
  localparam int unsigned ST_ALL_ONE_BIT = 2;

  // ==========================================================================
  // Reset values and timing counts
  // ==========================================================================
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
  localparam logic [4:0] FIVE_BIT_RESET = 5'h00;
  localparam logic [7:0] PCR_RESET = 8'h00;
  localparam logic [3:0] EIR_RESET = 4'h0;
  localparam logic [6:0] SYNC_MARGIN = 7'h22;
  localparam int unsigned LOSS_WINDOW = 64;
  localparam int unsigned LOSS_ERRORS = 8;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [31:0] pattern;
    logic [4:0] last_tap;
    logic [4:0] fb_tap;
    logic repetitive;
    logic [2:0] err_rate;
  } gen_cfg_t;

  // Bits between forced errors for rate codes 1..7 (one in ten down to one in ten million).
  function automatic logic [23:0] rate_period(input logic [2:0] code);
    logic [23:0] p;
    p = 24'h00_0000;
    case (code)
      3'h1: p = 24'h00_000a;
      3'h2: p = 24'h00_0064;
      3'h3: p = 24'h00_03e8;
      3'h4: p = 24'h00_2710;
      3'h5: p = 24'h01_86a0;
      3'h6: p = 24'h0f_4240;
      3'h7: p = 24'h98_9680;
      default: p = 24'h00_0000;
    endcase
    return p;
  endfunction

endpackage

// ---- bert_pattern_gen.sv ----
// Transmit pattern generator with load sequencing and error insertion.
`timescale 1ns/10ps
module bert_pattern_gen (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire bert_pkg::gen_cfg_t i_cfg,
  input wire logic i_load,
  input wire logic i_tick,
  input wire logic i_single,
  output logic o_single_pending,
  output logic o_bit
);

  logic [31:0] gen_reg;
  logic load_pend_reg;
  logic [1:0] load_stage_reg;
  logic single_reg;
  logic [23:0] rate_cnt_reg;
  logic [23:0] period;
  logic rate_hit;
  logic inject;
  logic feedback;
  logic emit;

  // ==========================================================================
  // Feedback and error selection
  // ==========================================================================
  assign period = bert_pkg::rate_period(i_cfg.err_rate);
  assign rate_hit = (i_cfg.err_rate != 3'h0) && (rate_cnt_reg >= period - 24'h00_0001);
  assign inject = single_reg | rate_hit;
  assign feedback = i_cfg.repetitive ? gen_reg[i_cfg.last_tap] :
                    (gen_reg[i_cfg.last_tap] ^ gen_reg[i_cfg.fb_tap]);
  // Bits leave only once the load sequence has run its three edges.
  assign emit = i_tick && !load_pend_reg && (load_stage_reg != 2'h2);
  assign o_single_pending = single_reg;

  // ==========================================================================
  // Load sequencing
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      load_pend_reg <= 1'b0;
      load_stage_reg <= 2'h0;
    end else begin
      if (i_tick && load_pend_reg) begin
        load_pend_reg <= i_load;
        load_stage_reg <= 2'h2;
      end else if (i_load) begin
        load_pend_reg <= 1'b1;
      end else if (i_tick && load_stage_reg != 2'h0) begin
        load_stage_reg <= load_stage_reg - 2'h1;
      end
    end
  end

  // ==========================================================================
  // Shift register and serial output
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gen_reg <= bert_pkg::PATTERN_RESET;
      o_bit <= 1'b0;
    end else if (i_tick && load_pend_reg) begin
      gen_reg <= i_cfg.pattern;
    end else if (emit) begin
      o_bit <= gen_reg[i_cfg.last_tap] ^ inject;
      gen_reg <= {gen_reg[30:0], feedback};
    end
  end

  // ==========================================================================
  // Error insertion
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      single_reg <= 1'b0;
      rate_cnt_reg <= 24'h00_0000;
    end else begin
      if (i_single) begin
        single_reg <= 1'b1;
      end else if (emit) begin
        single_reg <= 1'b0;
      end
      if (i_cfg.err_rate == 3'h0) begin
        rate_cnt_reg <= 24'h00_0000;
      end else if (emit) begin
        rate_cnt_reg <= rate_hit ? 24'h00_0000 : rate_cnt_reg + 24'h00_0001;
      end
    end
  end

endmodule

// ---- bert_core.sv ----
// Bit error rate tester top: APB registers, pin synchronisers, receiver and counters.
//
// What this block does
// - Transmit and receive run fully independently.
// - Pseudorandom pattern from programmable polynomial.
// - Repetitive pattern of 1 to 32 bits.
// - One tap fixed at length minus one.
// - Second tap programmable feedback position.
// - Load edge copies pattern into generator.
// - Pattern MSB out after third clock edge.
// - Load pin ORed with control bit 7.
// - Sync enable and resync bits steer synchronizer.
// - Pseudorandom check also accepts all zeros, not all ones.
// - Lock after 34 plus n clean bits.
// - Repetitive mode locks on same-length pattern.
// - While locked, each mismatch counts an error.
// - 32-bit error and bit counts readable.
// - Single error or 1e-1..1e-7 rates.
// - Lock holds at error rates near 1e-2.
// - Test input floats all outputs.
// - Load-count edge latches and clears counts.
// - Sync-loss output is live, active high.
// - Interrupt output active low, open drain.
`timescale 1ns/10ps
module bert_core #(
  parameter int unsigned LOSS_WINDOW = bert_pkg::LOSS_WINDOW,
  parameter int unsigned LOSS_ERRORS = bert_pkg::LOSS_ERRORS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_transmit_load,
  input wire logic i_load_count,
  input wire logic i_test,
  input wire logic i_tx_bit_clock,
  input wire logic i_rx_clock,
  input wire logic i_rx_data,
  output logic o_tx_data,
  output logic o_tx_data_oe,
  output logic o_rx_sync_lost,
  output logic o_rx_sync_lost_oe,
  output logic o_int_n_o,
  output logic o_int_n_oe
);

  localparam int unsigned PIN_TXC = 0;
  localparam int unsigned PIN_RXC = 1;
  localparam int unsigned PIN_RXD = 2;
  localparam int unsigned PIN_TL = 3;
  localparam int unsigned PIN_LC = 4;
  localparam int unsigned PIN_TEST = 5;
  localparam logic [6:0] WIN_LAST = 7'(LOSS_WINDOW - 1);
  localparam logic [6:0] ERR_LIMIT = 7'(LOSS_ERRORS);

  logic [31:0] pattern_set_regs;
  logic [4:0] pattern_length_reg;
  logic [4:0] tap_select_reg;
  logic [7:0] pattern_control_reg;
  logic [2:0] error_insert_reg;
  logic [31:0] received_pattern_regs;
  logic [31:0] error_count_latch;
  logic [31:0] bit_count_latch;
  logic [31:0] ref_reg;
  logic [31:0] bit_cnt_reg;
  logic [31:0] err_cnt_reg;
  logic [6:0] good_cnt_reg;
  logic [6:0] win_cnt_reg;
  logic [6:0] win_err_reg;
  logic sync_reg;
  logic tl_prev_reg;
  logic lc_prev_reg;
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [5:0] pin_s3_reg;
  logic wr_en;
  logic rd_setup;
  logic resync_pulse;
  logic single_pulse;
  logic tx_tick;
  logic rx_tick;
  logic rx_bit;
  logic tl_level;
  logic lc_level;
  logic tl_edge;
  logic lc_edge;
  logic test_mode;
  logic expected;
  logic rx_err;
  logic all_one;
  logic all_zero;
  logic single_pending;
  logic tx_bit;
  logic [6:0] lock_need;
  logic [31:0] rd_value;
  logic rd_ok;
  bert_pkg::gen_cfg_t gen_cfg;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Every pin is asynchronous to i_clk; the third stage only feeds edge detection.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      pin_s3_reg <= 6'h00;
    end else begin
      pin_s1_reg <= {i_test, i_load_count, i_transmit_load, i_rx_data, i_rx_clock,
                     i_tx_bit_clock};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign tx_tick = pin_s2_reg[PIN_TXC] & ~pin_s3_reg[PIN_TXC];
  assign rx_tick = pin_s2_reg[PIN_RXC] & ~pin_s3_reg[PIN_RXC];
  assign rx_bit = pin_s2_reg[PIN_RXD];
  assign test_mode = pin_s2_reg[PIN_TEST];
  assign tl_level = pin_s2_reg[PIN_TL] | pattern_control_reg[bert_pkg::PCR_TL_BIT];
  assign lc_level = pin_s2_reg[PIN_LC] | pattern_control_reg[bert_pkg::PCR_LC_BIT];
  assign tl_edge = tl_level & ~tl_prev_reg;
  assign lc_edge = lc_level & ~lc_prev_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tl_prev_reg <= 1'b0;
      lc_prev_reg <= 1'b0;
    end else begin
      tl_prev_reg <= tl_level;
      lc_prev_reg <= lc_level;
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  // Zero wait states: read data is captured in the setup cycle so that it comes
  // from flip-flops during the access phase.
  assign o_pready = 1'b1;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;
  assign resync_pulse = wr_en && (i_paddr == bert_pkg::OFF_PATTERN_CONTROL) &&
                        i_pwdata[bert_pkg::PCR_RESYNC_BIT];
  assign single_pulse = wr_en && (i_paddr == bert_pkg::OFF_ERROR_INSERT) &&
                        i_pwdata[bert_pkg::EIR_SINGLE_BIT];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pattern_set_regs <= bert_pkg::PATTERN_RESET;
      pattern_length_reg <= bert_pkg::FIVE_BIT_RESET;
      tap_select_reg <= bert_pkg::FIVE_BIT_RESET;
      pattern_control_reg <= bert_pkg::PCR_RESET;
      error_insert_reg <= bert_pkg::EIR_RESET[2:0];
    end else if (wr_en) begin
      if (i_paddr == bert_pkg::OFF_PATTERN_SET) begin
        pattern_set_regs <= i_pwdata;
      end else if (i_paddr == bert_pkg::OFF_PATTERN_LENGTH) begin
        pattern_length_reg <= i_pwdata[4:0];
      end else if (i_paddr == bert_pkg::OFF_TAP_SELECT) begin
        tap_select_reg <= i_pwdata[4:0];
      end else if (i_paddr == bert_pkg::OFF_PATTERN_CONTROL) begin
        // The resync bit is a command and is never stored.
        pattern_control_reg <= i_pwdata[7:0] & ~(8'h01 << bert_pkg::PCR_RESYNC_BIT);
      end else if (i_paddr == bert_pkg::OFF_ERROR_INSERT) begin
        error_insert_reg <= i_pwdata[bert_pkg::EIR_RATE_LSB +: bert_pkg::EIR_RATE_W];
      end
    end
  end

  always_comb begin
    rd_value = bert_pkg::READ_ZERO;
    rd_ok = 1'b1;
    if (i_paddr == bert_pkg::OFF_PATTERN_SET) begin
      rd_value = pattern_set_regs;
    end else if (i_paddr == bert_pkg::OFF_PATTERN_LENGTH) begin
      rd_value = {27'h000_0000, pattern_length_reg};
    end else if (i_paddr == bert_pkg::OFF_TAP_SELECT) begin
      rd_value = {27'h000_0000, tap_select_reg};
    end else if (i_paddr == bert_pkg::OFF_PATTERN_CONTROL) begin
      rd_value = {24'h00_0000, pattern_control_reg};
    end else if (i_paddr == bert_pkg::OFF_ERROR_INSERT) begin
      rd_value = {28'h000_0000, single_pending, error_insert_reg};
    end else if (i_paddr == bert_pkg::OFF_STATUS) begin
      rd_value = {29'h0000_0000, all_one, all_zero, sync_reg};
    end else if (i_paddr == bert_pkg::OFF_RECEIVED_PATTERN) begin
      rd_value = received_pattern_regs;
    end else if (i_paddr == bert_pkg::OFF_ERROR_COUNT) begin
      rd_value = error_count_latch;
    end else if (i_paddr == bert_pkg::OFF_BIT_COUNT) begin
      rd_value = bit_count_latch;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= bert_pkg::READ_ZERO;
      o_pslverr <= 1'b0;
    end else if (rd_setup) begin
      o_prdata <= i_pwrite ? bert_pkg::READ_ZERO : rd_value;
      o_pslverr <= ~rd_ok;
    end
  end

  // ==========================================================================
  // Transmit section
  // ==========================================================================
  assign gen_cfg = '{pattern: pattern_set_regs, last_tap: pattern_length_reg,
                     fb_tap: tap_select_reg,
                     repetitive: pattern_control_reg[bert_pkg::PCR_MODE_BIT],
                     err_rate: error_insert_reg};

  // The transmitter shares only configuration with the receiver.
  bert_pattern_gen u_gen (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_cfg(gen_cfg),
    .i_load(tl_edge),
    .i_tick(tx_tick),
    .i_single(single_pulse),
    .o_single_pending(single_pending),
    .o_bit(tx_bit)
  );

  // ==========================================================================
  // Receive synchroniser
  // ==========================================================================
  // While hunting the reference follows the line; once locked it runs free, so
  // a line error costs one count instead of spreading through the taps.
  assign expected = pattern_control_reg[bert_pkg::PCR_MODE_BIT] ?
                    ref_reg[pattern_length_reg] :
                    (ref_reg[pattern_length_reg] ^ ref_reg[tap_select_reg]);
  assign rx_err = rx_bit ^ expected;
  assign lock_need = bert_pkg::SYNC_MARGIN + {2'h0, pattern_length_reg} + 7'h01;
  assign all_one = &received_pattern_regs;
  assign all_zero = ~|received_pattern_regs;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      received_pattern_regs <= bert_pkg::PATTERN_RESET;
      ref_reg <= bert_pkg::PATTERN_RESET;
    end else if (rx_tick) begin
      received_pattern_regs <= {received_pattern_regs[30:0], rx_bit};
      ref_reg <= {ref_reg[30:0], sync_reg ? expected : rx_bit};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_reg <= 1'b0;
      good_cnt_reg <= 7'h00;
      win_cnt_reg <= 7'h00;
      win_err_reg <= 7'h00;
    end else if (resync_pulse) begin
      sync_reg <= 1'b0;
      good_cnt_reg <= 7'h00;
    end else if (rx_tick && !sync_reg) begin
      win_cnt_reg <= 7'h00;
      win_err_reg <= 7'h00;
      if (!pattern_control_reg[bert_pkg::PCR_SYNC_EN_BIT] || rx_err) begin
        good_cnt_reg <= 7'h00;
      end else if (good_cnt_reg + 7'h01 >= lock_need) begin
        sync_reg <= 1'b1;
        good_cnt_reg <= 7'h00;
      end else begin
        good_cnt_reg <= good_cnt_reg + 7'h01;
      end
    end else if (rx_tick) begin
      // Apart from a resync command, lock is dropped only on a burst of errors within one window.
      if (win_err_reg + {6'h00, rx_err} >= ERR_LIMIT) begin
        sync_reg <= 1'b0;
        win_cnt_reg <= 7'h00;
        win_err_reg <= 7'h00;
      end else if (win_cnt_reg == WIN_LAST) begin
        win_cnt_reg <= 7'h00;
        win_err_reg <= 7'h00;
      end else begin
        win_cnt_reg <= win_cnt_reg + 7'h01;
        win_err_reg <= win_err_reg + {6'h00, rx_err};
      end
    end
  end

  // ==========================================================================
  // Bit and error counters
  // ==========================================================================
  // A latch edge in the same cycle as a counted bit keeps that bit in the new period.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt_reg <= bert_pkg::READ_ZERO;
      err_cnt_reg <= bert_pkg::READ_ZERO;
      bit_count_latch <= bert_pkg::READ_ZERO;
      error_count_latch <= bert_pkg::READ_ZERO;
    end else begin
      if (lc_edge) begin
        bit_count_latch <= bit_cnt_reg;
        error_count_latch <= err_cnt_reg;
        bit_cnt_reg <= {31'h0000_0000, rx_tick & sync_reg};
        err_cnt_reg <= {31'h0000_0000, rx_tick & sync_reg & rx_err};
      end else if (rx_tick && sync_reg) begin
        bit_cnt_reg <= bit_cnt_reg + 32'h0000_0001;
        err_cnt_reg <= err_cnt_reg + {31'h0000_0000, rx_err};
      end
    end
  end

  // ==========================================================================
  // Output pins
  // ==========================================================================
  assign o_tx_data = tx_bit;
  assign o_tx_data_oe = ~test_mode;
  assign o_rx_sync_lost = ~sync_reg;
  assign o_rx_sync_lost_oe = ~test_mode;
  assign o_int_n_o = 1'b0;
  assign o_int_n_oe = pattern_control_reg[bert_pkg::PCR_INT_EN_BIT] & ~sync_reg &
                      ~test_mode;

endmodule

// ---- bert_core_assertions.sv ----
// Port-level property checker for the bit error rate tester top.
`timescale 1ns/10ps
module bert_core_assertions #(
  parameter int unsigned LOSS_WINDOW = 64,
  parameter int unsigned LOSS_ERRORS = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_test,
  input wire logic i_tx_bit_clock,
  input wire logic i_rx_clock,
  input wire logic o_tx_data,
  input wire logic o_tx_data_oe,
  input wire logic o_rx_sync_lost,
  input wire logic o_rx_sync_lost_oe,
  input wire logic o_int_n_o,
  input wire logic o_int_n_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire setup = i_psel && !i_penable;
  // ==========================================================================
  // Register port
  // ==========================================================================
  a_pready_high: assert property (o_pready) else $error("pready low");
  a_unmapped_err: assert property (setup && i_paddr > 8'h20 |=> o_pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (setup && i_paddr <= 8'h20 && i_paddr[1:0] == 2'h0
    |=> !o_pslverr) else $error("mapped access flagged");
  a_write_zero: assert property (setup && i_pwrite |=> o_prdata == 32'h0000_0000)
    else $error("write returned data");
  // ==========================================================================
  // Pins
  // ==========================================================================
  // Four samples cover the two-flop synchroniser in front of the test pin.
  a_test_floats: assert property (i_test [*4] |-> !(o_tx_data_oe || o_rx_sync_lost_oe
    || o_int_n_oe)) else $error("outputs driven in test");
  a_test_drives: assert property (!i_test [*4] |-> o_tx_data_oe && o_rx_sync_lost_oe)
    else $error("outputs floating");
  a_int_open_drain: assert property (o_int_n_o == 1'b0) else $error("int drives high");
  a_int_when_lost: assert property (o_int_n_oe |-> o_rx_sync_lost && o_rx_sync_lost_oe)
    else $error("int while locked");
  a_tx_gap_hold: assert property (!i_tx_bit_clock [*6] |-> $stable(o_tx_data))
    else $error("tx moved without clock");
  a_lock_gap_hold: assert property ((!i_rx_clock && !i_psel) [*6]
    |-> $stable(o_rx_sync_lost)) else $error("sync moved without clock");
  c_lock: cover property ($fell(o_rx_sync_lost));
  c_unmapped: cover property (o_pslverr);
  c_float: cover property (!o_tx_data_oe);
endmodule

// ---- bert_link_model.sv ----
// Far-end link model: gated bit clock and loopback of the transmit line.
`timescale 1ns/10ps
module bert_link_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_tx_data,
  input wire logic i_tx_oe,
  output logic o_bit_clk,
  output logic o_rx_data
);
  logic [2:0] cnt_reg;
  logic last_reg;
  // ==========================================================================
  // Bit clock
  // ==========================================================================
  // Stopping only at the end of a full period keeps every pulse long enough to be sampled.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= 3'h0;
    end else if (i_run || cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  assign o_bit_clk = cnt_reg[2];
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_reg <= 1'b0;
    end else if (i_tx_oe) begin
      last_reg <= i_tx_data;
    end
  end
  // A released transmit line shows the inverse of its last driven level.
  assign o_rx_data = i_tx_oe ? i_tx_data : ~last_reg;
endmodule

// ---- tb_bert_core.sv ----
// Self-checking bench for the bit error rate tester core.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_bert_core;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [7:0] pat = 8'hb4;
  logic [31:0] i_pwdata = 32'h0000_0000, rd, o_prdata;
  logic i_transmit_load = 1'b0, i_load_count = 1'b0, i_test = 1'b0, run = 1'b0, err;
  logic o_pready, o_pslverr, o_tx_data, o_tx_data_oe, o_rx_sync_lost, o_rx_sync_lost_oe;
  logic o_int_n_o, o_int_n_oe, bclk, rx;
  int n_mismatch = 0, compares = 0;
  wire int_line = o_int_n_oe ? o_int_n_o : 1'b1;
  row_t rows[5] = '{'{8'h00, 32'hffff_ffb4, 32'hffff_ffb4, 1'b0},
    '{8'h04, 32'hffff_ffe7, 32'h0000_0007, 1'b0}, '{8'h08, 32'h0000_0003, 32'h0000_0003, 1'b0},
    '{8'h24, 32'h1234_5678, 32'h0000_0000, 1'b1}, '{8'h0c, 32'h0000_0003, 32'h0000_0003, 1'b0}};
  bert_core u_bert_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_transmit_load(i_transmit_load),
    .i_load_count(i_load_count), .i_test(i_test), .i_tx_bit_clock(bclk), .i_rx_clock(bclk),
    .i_rx_data(rx), .o_tx_data(o_tx_data), .o_tx_data_oe(o_tx_data_oe),
    .o_rx_sync_lost(o_rx_sync_lost), .o_rx_sync_lost_oe(o_rx_sync_lost_oe),
    .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe));
  bert_link_model u_bert_link_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_run(run),
    .i_tx_data(o_tx_data), .i_tx_oe(o_tx_data_oe), .o_bit_clk(bclk), .o_rx_data(rx));
  always #5 i_clk = ~i_clk;
  task automatic print_verdict();
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin n_mismatch++; print_verdict(); end
  endtask
  task automatic wait_bclk(input logic v);
    int n;
    n = 0;
    while (bclk !== v && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 50) begin n_mismatch++; print_verdict(); end
  endtask
  task automatic run_bits(input int m);
    wait_bclk(1'b0);
    run <= 1'b1;
    for (int k = 0; k < m; k++) begin
      wait_bclk(1'b1);
      if (k < m - 1) wait_bclk(1'b0);
    end
    @(posedge i_clk);
    run <= 1'b0;
  endtask
  task automatic count_check(input logic [31:0] e, input logic [31:0] c);
    apb(1'b1, 8'h0c, 32'h0000_0013);
    apb(1'b1, 8'h0c, 32'h0000_0003);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    `CHK("err_count", e, rd)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("bit_count", c, rd)
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    `CHK("sync_lost", 1'b1, o_rx_sync_lost)
    `CHK("int_line", 1'b1, int_line)
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("reg_read", rows[i].r, rd)
      `CHK("reg_err", rows[i].e, err)
    end
    i_transmit_load <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_transmit_load <= 1'b0;
    run <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      wait_bclk(1'b1);
      wait_bclk(1'b0);
      repeat (2) @(posedge i_clk);
      if (k >= 2) `CHK("tx_bit", pat[7 - ((k - 2) % 8)], o_tx_data)
    end
    wait_bclk(1'b1);
    run <= 1'b0;
    run_bits(60);
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK("lock", 3'b001, rd[2:0])
    `CHK("sync_lost", 1'b0, o_rx_sync_lost)
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK("rx_pattern", 32'h9696_9696, rd)
    i_load_count <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_load_count <= 1'b0;
    apb(1'b1, 8'h10, 32'h0000_0008);
    run_bits(40);
    repeat (8) @(posedge i_clk);
    count_check(32'd1, 32'd40);
    apb(1'b1, 8'h10, 32'h0000_0001);
    run_bits(100);
    apb(1'b1, 8'h10, 32'h0000_0000);
    run_bits(1);
    repeat (8) @(posedge i_clk);
    count_check(32'd10, 32'd101);
    `CHK("sync_lost", 1'b0, o_rx_sync_lost)
    apb(1'b1, 8'h0c, 32'h0000_000f);
    repeat (4) @(posedge i_clk);
    `CHK("sync_lost", 1'b1, o_rx_sync_lost)
    `CHK("int_line", 1'b0, int_line)
    i_test <= 1'b1;
    repeat (5) @(posedge i_clk);
    `CHK("oe", 3'b000, {o_tx_data_oe, o_rx_sync_lost_oe, o_int_n_oe})
    `CHK("int_line", 1'b1, int_line)
    i_test <= 1'b0;
    repeat (5) @(posedge i_clk);
    // Pseudorandom run: five-bit register, tap 3, loaded through the control bit.
    apb(1'b1, 8'h04, 32'h0000_0004);
    apb(1'b1, 8'h0c, 32'h0000_0082);
    apb(1'b1, 8'h0c, 32'h0000_0002);
    run_bits(60);
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK("prbs_lock", 3'b001, rd[2:0])
    `CHK("sync_lost", 1'b0, o_rx_sync_lost)
    print_verdict();
  end
endmodule
bind bert_core bert_core_assertions #(.LOSS_WINDOW(LOSS_WINDOW), .LOSS_ERRORS(LOSS_ERRORS))
  u_bert_core_assertions (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_test(i_test),
  .i_tx_bit_clock(i_tx_bit_clock), .i_rx_clock(i_rx_clock), .o_tx_data(o_tx_data),
  .o_tx_data_oe(o_tx_data_oe), .o_rx_sync_lost(o_rx_sync_lost),
  .o_rx_sync_lost_oe(o_rx_sync_lost_oe), .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe));
